// ---- core/serial_port.sv ----
// serial port modes 0/1 with baud generation and axi4-lite registers
//
// Operation
// - mode 0 bit rate is clock over six
// - mode 2 rate clock/32, or /16 doubled
// - modes 1/3 rate from timer 1 overflow
// - mode 0: data pin, shift clock, 8 bits
// - mode 0 write loads marker, send follows
// - mode 0 shift clock phases, shift at S6P2
// - mode 0 marker ends send, sets tx flag
// - mode 0 receive preset then rx active
// - mode 0 clock toggles, sample at S5P2
// - mode 0 final shift loads buffer, flag
// - frame: start 0, 8 data lsb first, stop
// - mode 1 send waits for counter rollover
// - start bit, then data, then first shift
// - mode 1 marker ends send, sets tx flag
// - falling edge resets counter, presets 1ff
// - majority of samples seven, eight, nine
// - false start bit restarts edge search
// - nine bit register, final shift loads
// - load only if flag clear, and stop ok or mp clear
// - buffer write transmit, read receive
// - receive starts only with enable set
// - framing error sticky until cleared
`timescale 1ns/10ps
`default_nettype none

module serial_port
(
    // clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // axi4-lite write
    input  wire logic [serial_pkg::AXI_AW-1:0] awaddr,
    input  wire logic [2:0]                   awprot,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    // axi4-lite read
    input  wire logic [serial_pkg::AXI_AW-1:0] araddr,
    input  wire logic [2:0]                   arprot,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    // serial pins
    input  wire logic                         serial_in_pin_i,
    output logic                              serial_in_pin_o,
    output logic                              serial_in_pin_oe,
    output logic                              serial_out_pin
);
    import serial_pkg::*;

    st_t  s;
    st_t  n;
    logic m0;
    logic ovf;
    logic src;
    logic tick;
    logic roll;
    logic maj;
    logic fall;
    logic do_wr;
    logic fe_clr;
    logic [AXI_AW-1:0] wa_al;
    logic [AXI_AW-1:0] ra_al;

    assign m0    = s.mode == MODE0;
    assign ovf   = s.ph == PH_S6 && s.t1 == T1_MAX;
    assign maj   = (s.smp[0] & s.smp[1]) | (s.smp[0] & s.smp[2])
                 | (s.smp[1] & s.smp[2]);
    assign fall  = s.rs3 && !s.rs2;
    assign do_wr = s.aw_f && s.w_f && !s.bv;
    assign wa_al = {s.wa[AXI_AW-1:2], 2'h0};
    assign ra_al = {araddr[AXI_AW-1:2], 2'h0};
    assign fe_clr = do_wr && wa_al == OFF_CTL && s.ws[1] && !s.wd[CB_FE];

    always_comb
    begin
        n = s;
        // pin synchroniser; rs3 is the 16x edge sample
        n.rs1 = serial_in_pin_i;
        n.rs2 = s.rs1;
        n.ph  = (s.ph == PH_S6) ? PH_S1 : s.ph + 3'h1;
        // timer 1 runs as 8-bit auto reload, one count per machine cycle
        if (s.ph == PH_S6)
        begin
            n.t1 = ovf ? s.th1 : s.t1 + 8'h01;
        end
        // mode 2 counts clocks, other modes count timer overflows
        src = (s.mode == MODE2) ? 1'b1 : ovf;
        if (src)
        begin
            n.half = ~s.half;
        end
        tick = src && (s.smod || s.half);
        roll = tick && s.cnt == CNT_LAST;
        if (tick)
        begin
            n.cnt = s.cnt + 4'h1;
            n.rs3 = s.rs2;
        end

        // axi write side; any order of address and data
        if (awvalid && s.awr)
        begin
            n.aw_f = 1'b1;
            n.wa   = awaddr;
        end
        if (wvalid && s.wr)
        begin
            n.w_f = 1'b1;
            n.wd  = wdata[8:0];
            n.ws  = wstrb[1:0];
        end
        if (s.bv && bready)
        begin
            n.bv = 1'b0;
        end
        if (do_wr)
        begin
            n.aw_f = 1'b0;
            n.w_f  = 1'b0;
            n.bv   = 1'b1;
            n.br   = RESP_OKAY;
            case (wa_al)
                OFF_BUF:
                begin
                    if (s.ws[0])
                    begin
                        n.tsr  = {1'b1, s.wd[7:0]};
                        n.treq = 1'b1;
                    end
                end
                OFF_CTL:
                begin
                    if (s.ws[0])
                    begin
                        n.ri   = s.wd[CB_RI];
                        n.ti   = s.wd[CB_TI];
                        n.rb8  = s.wd[CB_RB8];
                        n.ren  = s.wd[CB_REN];
                        n.mp   = s.wd[CB_MP];
                        n.mode = s.wd[CB_MODE +: 2];
                    end
                    if (fe_clr)
                    begin
                        n.fe = 1'b0;
                    end
                end
                OFF_PWR:
                begin
                    if (s.ws[0])
                    begin
                        n.smod = s.wd[0];
                    end
                end
                OFF_RLD:
                begin
                    if (s.ws[0])
                    begin
                        n.th1 = s.wd[7:0];
                    end
                end
                default:
                begin
                    n.br = RESP_SLVERR;
                end
            endcase
        end

        // hardware sets below override software clears above
        if (m0)
        begin
            // transmit: send rises at the S1 after the first S6 that follows the write
            if (s.treq && s.ph == PH_S6)
            begin
                n.tact = 1'b1;
                n.treq = 1'b0;
            end
            if (s.tact && !s.tend && s.ph == PH_S6)
            begin
                n.tsr = {1'b0, s.tsr[8:1]};
                if (s.tsr[8:1] == TX_MARK)
                begin
                    n.tend = 1'b1;
                end
            end
            if (s.tend && s.ph == PH_S1)
            begin
                n.tact = 1'b0;
                n.tend = 1'b0;
                n.ti   = 1'b1;
            end
            // receive starts on enable with done flag clear
            if (s.ren && !s.ri && !s.ract && !s.rarm && !s.rpre)
            begin
                n.rarm = 1'b1;
            end
            if (s.rarm && s.ph == PH_S6)
            begin
                n.rsr[7:0] = RX0_PRESET;
                n.rarm     = 1'b0;
                n.rpre     = 1'b1;
            end
            if (s.rpre)
            begin
                n.ract = 1'b1;
                n.rpre = 1'b0;
            end
            if (s.ract && s.ph == PH_S5)
            begin
                n.smp[0] = s.rs2;
            end
            if (s.ract && !s.rend && s.ph == PH_S6)
            begin
                n.rsr[7:0] = {s.rsr[6:0], s.smp[0]};
                if (!s.rsr[7])
                begin
                    // first bit in is lsb, so reverse on load
                    n.rbuf = {<<{s.rsr[6:0], s.smp[0]}};
                    n.rend = 1'b1;
                end
            end
            if (s.rend && s.ph == PH_S1)
            begin
                n.ract = 1'b0;
                n.rend = 1'b0;
                n.ri   = 1'b1;
            end
        end
        else
        begin
            // bit times follow the counter, not the write
            if (s.treq && roll)
            begin
                n.tgo  = 1'b1;
                n.treq = 1'b0;
            end
            if (s.tgo && s.ph == PH_S1)
            begin
                n.tact = 1'b1;
                n.tdat = 1'b0;
                n.tgo  = 1'b0;
            end
            if (s.tact && roll)
            begin
                if (!s.tdat)
                begin
                    n.tdat = 1'b1;
                end
                else
                begin
                    n.tsr = {1'b0, s.tsr[8:1]};
                    if (s.tsr[8:1] == TX_MARK)
                    begin
                        n.tact = 1'b0;
                        n.tdat = 1'b0;
                        n.ti   = 1'b1;
                    end
                end
            end
            // edge search only while enabled and idle
            if (!s.ract && s.ren && tick && fall)
            begin
                n.cnt  = 4'h0;
                n.rsr  = RX1_PRESET;
                n.ract = 1'b1;
                n.rfst = 1'b1;
            end
            if (s.ract && tick && s.cnt >= SMP_LO && s.cnt <= SMP_HI)
            begin
                n.smp = {s.smp[1:0], s.rs2};
            end
            if (s.ract && roll)
            begin
                if (s.rfst)
                begin
                    if (maj)
                    begin
                        n.ract = 1'b0;
                    end
                    else
                    begin
                        n.rfst = 1'b0;
                        n.rsr  = {s.rsr[7:0], 1'b0};
                    end
                end
                else if (!s.rsr[8])
                begin
                    // maj is the stop bit here
                    if (!s.ri && (!s.mp || maj))
                    begin
                        n.rbuf = {<<{s.rsr[7:0]}};
                        n.rb8  = maj;
                        n.ri   = 1'b1;
                    end
                    if (!maj)
                    begin
                        n.fe = 1'b1;
                    end
                    n.ract = 1'b0;
                end
                else
                begin
                    n.rsr = {s.rsr[7:0], maj};
                end
            end
        end

        // pins registered from next state
        if (n.mode == MODE0)
        begin
            // shift clock low in S3..S5 while busy
            n.txd = (n.tact || n.ract)
                  ? !(n.ph >= PH_S3 && n.ph <= PH_S5) : 1'b1;
            n.dout = n.tsr[0];
            n.doe  = n.tact;
        end
        else
        begin
            n.txd  = !n.tact ? 1'b1
                   : (n.tdat ? n.tsr[0] : 1'b0);
            n.dout = 1'b1;
            n.doe  = 1'b0;
        end

        // axi read side, one read outstanding
        if (s.rv && rready)
        begin
            n.rv = 1'b0;
        end
        if (arvalid && s.arr)
        begin
            n.rv = 1'b1;
            n.rr = RESP_OKAY;
            case (ra_al)
                OFF_BUF: n.rd = {24'h0, s.rbuf};
                OFF_CTL: n.rd = {21'h0, s.ract, s.tact, s.fe,
                                 s.mode, s.mp, s.ren, 1'b0,
                                 s.rb8, s.ti, s.ri};
                OFF_PWR: n.rd = {31'h0, s.smod};
                OFF_RLD: n.rd = {24'h0, s.th1};
                default:
                begin
                    n.rd = 32'h0;
                    n.rr = RESP_SLVERR;
                end
            endcase
        end
        n.awr = !n.aw_f;
        n.wr  = !n.w_f;
        n.arr = !n.rv;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= ST_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign awready          = s.awr;
    assign wready           = s.wr;
    assign bvalid           = s.bv;
    assign bresp            = s.br;
    assign arready          = s.arr;
    assign rvalid           = s.rv;
    assign rresp            = s.rr;
    assign rdata            = s.rd;
    assign serial_out_pin   = s.txd;
    assign serial_in_pin_o  = s.dout;
    assign serial_in_pin_oe = s.doe;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_m0_clock_low: assert property (
        m0 && s.tact && s.ph >= PH_S3 && s.ph <= PH_S5 |-> !s.txd)
        else $error("mode 0 shift clock not low in S3..S5");
    a_m0_send_start: assert property (
        m0 && $rose(s.tact) |-> s.ph == PH_S1 && $past(s.treq))
        else $error("mode 0 send not after request at S6");
    a_m1_send_start: assert property (
        !m0 && $rose(s.tact) |-> $past(s.ph) == PH_S1 && !s.txd)
        else $error("mode 1 send not at S1 with start bit");
    a_tx_done_flag: assert property (
        $fell(s.tact) |-> s.ti)
        else $error("send ended without tx done flag");
    a_m0_rx_preset: assert property (
        m0 && $rose(s.ract) |-> s.rsr[7:0] == RX0_PRESET)
        else $error("mode 0 receive started without preset");
    a_m1_edge_reset: assert property (
        !m0 && !s.ract && s.ren && tick && fall
        |=> s.ract && s.cnt == 4'h0 && s.rsr == RX1_PRESET)
        else $error("edge did not reset counter and preset");
    a_false_start: assert property (
        !m0 && s.ract && s.rfst && roll && maj |=> !s.ract)
        else $error("false start bit not rejected");
    a_no_enable: assert property (
        !m0 && !s.ren && !s.ract && !s.rpre |=> !s.ract)
        else $error("receive started while disabled");
    a_fe_sticky: assert property (
        s.fe && !fe_clr |=> s.fe)
        else $error("framing error cleared by itself");
    a_idle_mark: assert property (
        !m0 && !s.tact |-> s.txd)
        else $error("transmit line not idle high");
    a_t1_reload: assert property (
        ovf |=> s.t1 == $past(s.th1))
        else $error("timer 1 did not reload");
    a_b_hold: assert property (
        s.bv && !bready |=> s.bv && $stable(s.br))
        else $error("write response dropped early");

    c_m0_tx: cover property (m0 && $fell(s.tact));
    c_m1_rx: cover property (!m0 && $rose(s.ri));
    c_false: cover property (!m0 && s.ract && s.rfst && roll && maj);
    c_fe: cover property ($rose(s.fe));

endmodule // serial_port

`default_nettype wire

// ---- common/serial_pkg.sv ----
// shared constants and state layout for the serial port block
package serial_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_BUF = 8'h00;
    localparam logic [7:0] OFF_CTL = 8'h04;
    localparam logic [7:0] OFF_PWR = 8'h08;
    localparam logic [7:0] OFF_RLD = 8'h0c;
    localparam int         AXI_AW  = 8;

    // serial_control field positions
    localparam int CB_RI   = 0;
    localparam int CB_TI   = 1;
    localparam int CB_RB8  = 2;
    localparam int CB_REN  = 4;
    localparam int CB_MP   = 5;
    localparam int CB_MODE = 6;
    localparam int CB_FE   = 8;

    // machine cycle states, one clock each
    localparam logic [2:0] PH_S1 = 3'h0;
    localparam logic [2:0] PH_S3 = 3'h2;
    localparam logic [2:0] PH_S5 = 3'h4;
    localparam logic [2:0] PH_S6 = 3'h5;

    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE2 = 2'h2;

    localparam logic [3:0] CNT_LAST   = 4'hf;
    localparam logic [3:0] SMP_LO     = 4'h7;
    localparam logic [3:0] SMP_HI     = 4'h9;
    localparam logic [7:0] TX_MARK    = 8'h01;
    localparam logic [7:0] RX0_PRESET = 8'hfe;
    localparam logic [8:0] RX1_PRESET = 9'h1ff;
    localparam logic [7:0] T1_MAX     = 8'hff;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0]        ph;
        logic [7:0]        t1;
        logic              half;
        logic [3:0]        cnt;
        logic [8:0]        tsr;
        logic              treq, tgo, tact, tdat, tend;
        logic [8:0]        rsr;
        logic              rarm, rpre, ract, rfst, rend;
        logic [2:0]        smp;
        logic [7:0]        rbuf;
        logic              rb8, ti, ri, fe, ren, mp, smod;
        logic [1:0]        mode;
        logic [7:0]        th1;
        logic              rs1, rs2, rs3;
        logic              txd, dout, doe;
        logic              awr, wr, arr, bv, rv, aw_f, w_f;
        logic [1:0]        br, rr, ws;
        logic [AXI_AW-1:0] wa;
        logic [8:0]        wd;
        logic [31:0]       rd;
    } st_t;

    localparam st_t ST_RST = '{txd: 1'b1, rs1: 1'b1, rs2: 1'b1,
                               rs3: 1'b1, default: '0};

endpackage

// ---- verif/serial_peer.sv ----
// behavioural serial peer: async frames and mode 0 shift partner
`timescale 1ns/10ps
`default_nettype none

module serial_peer
(
    // clock
    input  wire logic aclk,
    // lines from the device
    input  wire logic line_in,
    input  wire logic dev_data,
    input  wire logic dev_oe,
    // line towards the device
    output logic      peer_data
);
    initial peer_data = 1'b1;

    // gmask flips one sixteenth of a bit at mid-bit, noise for the voter
    task automatic send_frame(input logic [7:0] d, input logic stp,
                              input int per, input logic [9:0] gmask);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++)
            for (int c = 0; c < per; c++)
            begin
                @(posedge aclk);
                peer_data <= f[i] ^ (gmask[i] && c >= per / 2
                                     && c < per / 2 + per / 16);
            end
        @(posedge aclk);
        peer_data <= 1'b1;
    endtask

    task automatic send_pulse(input int n);
        for (int c = 0; c < n; c++)
        begin
            @(posedge aclk);
            peer_data <= 1'b0;
        end
        @(posedge aclk);
        peer_data <= 1'b1;
    endtask

    // mid-bit sampling; ok drops on a bad start or stop level
    task automatic recv_frame(input int per, output logic [7:0] d,
                              output logic ok);
        logic [9:0] f;
        int         n;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (line_in !== 1'b0 && n < 40 * per);
        repeat (per / 2) @(posedge aclk);
        for (int i = 0; i < 10; i++)
        begin
            f[i] = line_in;
            repeat (per) @(posedge aclk);
        end
        d = f[8:1];
        ok = f[0] === 1'b0 && f[9] === 1'b1;
    endtask

    // capture on falling shift clock; lo counts low clocks after the first
    task automatic m0_recv(output logic [7:0] d, output int lo,
                           output int gap);
        int   k, c, last;
        logic p;
        k = 0;
        c = 0;
        lo = 0;
        last = 0;
        p = 1'b1;
        while (k < 8 && c < 2000)
        begin
            @(posedge aclk);
            c++;
            if (k > 0 && !line_in)
                lo++;
            if (dev_oe && p && !line_in)
            begin
                d[k] = dev_data;
                k++;
                gap = c - last;
                last = c;
            end
            p = line_in;
        end
    endtask

    // new data on each rising shift clock, after the device has sampled
    task automatic m0_send(input logic [7:0] d);
        int   k, c;
        logic p;
        k = 0;
        c = 0;
        p = 1'b1;
        @(posedge aclk);
        peer_data <= d[0];
        while (k < 8 && c < 2000)
        begin
            @(posedge aclk);
            c++;
            if (!p && line_in)
            begin
                k++;
                // after the last bit drives the inverse of d[7]: never a stale level
                peer_data <= (k < 8) ? d[k % 8] : ~d[7];
            end
            p = line_in;
        end
    endtask
endmodule // serial_peer
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the serial port over axi4-lite
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import serial_pkg::*;

    logic              aclk, aresetn, awvalid, awready, wvalid, wready;
    logic              bvalid, bready, arvalid, arready, rvalid, rready;
    logic              pin_o, pin_oe, pin_i, out_pin, peer_data;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    int                n_fail, checks_done;

    // baud table rows: mode, doubler, reload
    localparam logic [1:0] MD [5] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
    localparam logic       DB [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    localparam logic [7:0] RL [5] = '{8'hff, 8'hff, 8'hfe, 8'hff, 8'hff};

    assign pin_i = pin_oe ? pin_o : peer_data;

    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;

    serial_port uut
    (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .awaddr          (awaddr),
        .awprot          (3'h0),
        .awvalid         (awvalid),
        .awready         (awready),
        .wdata           (wdata),
        .wstrb           (wstrb),
        .wvalid          (wvalid),
        .wready          (wready),
        .bresp           (bresp),
        .bvalid          (bvalid),
        .bready          (bready),
        .araddr          (araddr),
        .arprot          (3'h0),
        .arvalid         (arvalid),
        .arready         (arready),
        .rdata           (rdata),
        .rresp           (rresp),
        .rvalid          (rvalid),
        .rready          (rready),
        .serial_in_pin_i (pin_i),
        .serial_in_pin_o (pin_o),
        .serial_in_pin_oe(pin_oe),
        .serial_out_pin  (out_pin)
    );

    serial_peer peer
    (
        .aclk     (aclk),
        .line_in  (out_pin),
        .dev_data (pin_o),
        .dev_oe   (pin_oe),
        .peer_data(peer_data)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        logic ad, dd;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 1'b0;
        dd = 1'b0;
        do
        begin
            @(posedge aclk);
            if (!ad && awready === 1'b1)
            begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!dd && wready === 1'b1)
            begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!(ad && dd));
        // only the watchdog ends a wait for the answer
        do
            @(posedge aclk);
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] r;
        axi_wr(a, v, 4'h3, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d & m, e);
    endtask

    // the wait after the stop bit covers the flag update
    task automatic rx_frame(input logic [7:0] v, input logic stp,
                            input logic [9:0] g);
        peer.send_frame(v, stp, 96, g);
        repeat (96) @(posedge aclk);
    endtask

    // tests need some 15000 cycles; four times that means a hang
    initial
    begin
        repeat (60000) @(posedge aclk);
        n_fail++;
        print_verdict();
    end

    initial
    begin : main
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  got;
        logic        ok;
        int          lo, gap, per;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({31'h0, out_pin}, 32'h1);
        rdc(OFF_CTL, 32'hffffffff, 32'h0);
        rdc(OFF_PWR, 32'h1, 32'h0);
        axi_rd(8'h10, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        axi_wr(8'h10, 32'h0, 4'hf, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        // timer 1 as 8-bit auto-reload, reload per table row
        for (int i = 0; i < 5; i++)
        begin
            wr(OFF_PWR, {31'h0, DB[i]});
            wr(OFF_RLD, {24'h0, RL[i]});
            wr(OFF_CTL, {24'h0, MD[i], 6'h0});
            per = (MD[i] == MODE2) ? (DB[i] ? 16 : 32)
                                   : (DB[i] ? 96 : 192) * (256 - RL[i]);
            fork
                peer.recv_frame(per, got, ok);
                wr(OFF_BUF, 32'h5a + i);
            join
            chk({24'h0, got}, 32'h5a + i);
            chk({31'h0, ok}, 32'h1);
            rdc(OFF_CTL, 32'h202, 32'h2);
            chk({31'h0, out_pin}, 32'h1);
            wr(OFF_CTL, 32'h0);
        end
        wr(OFF_PWR, 32'h1);
        wr(OFF_RLD, 32'hff);
        wr(OFF_CTL, 32'h50);
        rx_frame(8'h3c, 1'b1, 10'h012);
        rdc(OFF_CTL, 32'h1ff, 32'h55);
        rdc(OFF_BUF, 32'hff, 32'h3c);
        wr(OFF_BUF, 32'h99);
        rdc(OFF_BUF, 32'hff, 32'h3c);
        wr(OFF_CTL, 32'h50);
        rx_frame(8'h77, 1'b0, 10'h0);
        // the 0x99 send has ended by now, so tx done is set again
        rdc(OFF_CTL, 32'h1ff, 32'h153);
        rdc(OFF_BUF, 32'hff, 32'h77);
        axi_wr(OFF_CTL, 32'h50, 4'h1, r);
        rx_frame(8'h21, 1'b1, 10'h0);
        rdc(OFF_CTL, 32'h1ff, 32'h155);
        rx_frame(8'h66, 1'b1, 10'h0);
        rdc(OFF_BUF, 32'hff, 32'h21);
        wr(OFF_CTL, 32'h70);
        rx_frame(8'h44, 1'b0, 10'h0);
        rdc(OFF_CTL, 32'h1, 32'h0);
        rdc(OFF_BUF, 32'hff, 32'h21);
        rx_frame(8'h45, 1'b1, 10'h0);
        rdc(OFF_CTL, 32'h1, 32'h1);
        rdc(OFF_BUF, 32'hff, 32'h45);
        wr(OFF_CTL, 32'h50);
        peer.send_pulse(12);
        repeat (300) @(posedge aclk);
        rdc(OFF_CTL, 32'h1, 32'h0);
        rx_frame(8'h12, 1'b1, 10'h0);
        rdc(OFF_BUF, 32'hff, 32'h12);
        wr(OFF_CTL, 32'h40);
        rx_frame(8'h34, 1'b1, 10'h0);
        rdc(OFF_CTL, 32'h1, 32'h0);
        rdc(OFF_BUF, 32'hff, 32'h12);
        wr(OFF_CTL, 32'h0);
        fork
            peer.m0_recv(got, lo, gap);
            wr(OFF_BUF, 32'ha5);
        join
        chk({24'h0, got}, 32'ha5);
        chk(32'(lo), 32'h15);
        chk(32'(gap), 32'h6);
        repeat (72) @(posedge aclk);
        rdc(OFF_CTL, 32'h7ff, 32'h2);
        wr(OFF_CTL, 32'h0);
        fork
            peer.m0_send(8'hc3);
            wr(OFF_CTL, 32'h10);
        join
        repeat (72) @(posedge aclk);
        rdc(OFF_CTL, 32'h7ff, 32'h11);
        rdc(OFF_BUF, 32'hff, 32'hc3);
        wr(OFF_CTL, 32'h0);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
